/* sim/uez_ctrl_tb.sv */
`timescale 1ns/1ps
module uez_ctrl_tb
   import uez_pkg::*;
;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = '0;
   logic [5:0]  sra = 6'h00;
   logic [31:0] rdat;
   logic [31:0] q;
   logic        wait_r;
   logic        irq;
   logic        hack;
   logic [7:0]  srd;
   logic [6:0]  dev_addr;
   uez_tok_t    tok;
   uez_rx_t     rx;
   uez_reply_t  reply;
   uez_reply_t  last;
   int          n_mismatch = 0;
   int          checks_done = 0;
   always #20 clk = ~clk;
   uez_ctrl dut (.clk(clk), .nrst(nrst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wait_r), .irq(irq), .tok(tok),
      .rx(rx), .host_ack(hack), .sie_rd_addr(sra), .sie_rd_data(srd), .reply(reply),
      .dev_addr(dev_addr));
   uez_host h (.clk(clk), .reply(reply), .tok(tok), .rx(rx), .ack(hack), .last(last));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // waits as long as the slave needs; only the watchdog ends a hung access
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= {24'h000000, d};
      do
         @(posedge clk);
      while (wait_r !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, e);
   endtask
   // length only means something on a data answer
   task automatic rp(input uez_code_t c, input logic [6:0] n);
      chk(32'({last.code, (c == RC_DATA) ? last.len : 7'h00}), 32'({c, n}));
   endtask
   task final_report();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
   initial
   begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      bus(1'b1, UEZ_REG_INVAL, 8'h00);
      rc(UEZ_REG_INVAL, 32'h01);
      bus(1'b1, UEZ_REG_PAIR, 8'hff);
      rc(UEZ_REG_PAIR, 32'h07);
      rc(8'h0f, 32'h00);
      rc(UEZ_REG_ENUM, 32'h01);
      bus(1'b1, UEZ_REG_IEN, 8'h03);
      h.send(PID_SETUP, 64'h0000_0000_0100_0680, 8, 1'b1);
      rp(RC_ACK, 7'h00);
      chk(32'(irq), 32'h1);
      rc(UEZ_REG_IRQ, 32'h03);
      rc(UEZ_WIN_SETUP + 8'h01, 32'h06);
      bus(1'b1, UEZ_REG_IRQ, 8'h03);
      rc(UEZ_REG_IRQ, 32'h00);
      chk(32'(irq), 32'h0);
      h.send(PID_IN, '0, 0, 1'b1);
      rp(RC_NAK, 7'h00);
      bus(1'b1, UEZ_REG_EPCS, 8'h02);
      h.send(PID_IN, '0, 0, 1'b1);
      rp(RC_DATA, 7'h00);
      h.hack();
      bus(1'b1, UEZ_REG_IEN, 8'h00);
      h.send(PID_SETUP, 64'h0, 8, 1'b0);
      rp(RC_NONE, 7'h00);
      rc(UEZ_REG_IRQ, 32'h01);
      chk(32'(irq), 32'h0);
      bus(1'b1, UEZ_REG_IRQ, 8'h01);
      h.send(PID_SETUP, 64'h0002_0000_0000_0880, 8, 1'b1);
      rc(UEZ_WIN_SETUP + 8'h01, 32'h08);
      h.send(PID_IN, '0, 0, 1'b1);
      rp(RC_NAK, 7'h00);
      bus(1'b1, UEZ_WIN_IN, 8'ha5);
      bus(1'b1, UEZ_WIN_IN + 8'h01, 8'h3c);
      bus(1'b1, UEZ_REG_INBC, 8'h02);
      h.send(PID_IN, '0, 0, 1'b1);
      rp(RC_DATA, 7'h02);
      sra <= 6'h01;
      repeat (2) @(posedge clk);
      chk(32'(srd), 32'h3c);
      h.hack();
      h.send(PID_OUT, '0, 0, 1'b1);
      rp(RC_NAK, 7'h00);
      bus(1'b1, UEZ_REG_EPCS, 8'h02);
      h.send(PID_OUT, '0, 0, 1'b1);
      rp(RC_ACK, 7'h00);
      h.send(PID_SETUP, 64'h0002_0000_0000_0900, 8, 1'b1);
      h.send(PID_OUT, 64'h0000_0000_0000_3c5a, 2, 1'b1);
      rp(RC_NAK, 7'h00);
      bus(1'b1, UEZ_REG_OUTBC, 8'h00);
      h.send(PID_OUT, 64'h0000_0000_0000_3c5a, 2, 1'b1);
      rp(RC_ACK, 7'h00);
      rc(UEZ_REG_OUTBC, 32'h02);
      rc(UEZ_WIN_OUT + 8'h01, 32'h3c);
      h.send(PID_IN, '0, 0, 1'b1);
      rp(RC_NAK, 7'h00);
      h.send(PID_SETUP, 64'h0000_0000_0000_0880, 8, 1'b1);
      bus(1'b1, UEZ_REG_EPCS, 8'h01);
      h.send(PID_IN, '0, 0, 1'b1);
      rp(RC_STALL, 7'h00);
      h.send(PID_SETUP, 64'h0000_0000_0000_0880, 8, 1'b1);
      rp(RC_ACK, 7'h00);
      rc(UEZ_REG_EPCS, 32'h02);
      bus(1'b1, UEZ_REG_IRQ, 8'h03);
      h.send(PID_SETUP, 64'h0000_0000_0023_0500, 8, 1'b1);
      rc(UEZ_REG_IRQ, 32'h01);
      h.send(PID_IN, '0, 0, 1'b1);
      rp(RC_DATA, 7'h00);
      h.hack();
      repeat (2) @(posedge clk);
      chk(32'(dev_addr), 32'h23);
      // a bus reset in mid-run drops the address and leaves the enumeration flag set
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      chk(32'(dev_addr), 32'h00);
      rc(UEZ_REG_ENUM, 32'h01);
      final_report();
   end
endmodule

/* sim/uez_host.sv */
`timescale 1ns/1ps
module uez_host
   import uez_pkg::*;
(
   input  wire logic clk,   // core clock
   input  uez_reply_t reply, // device answer
   output uez_tok_t   tok,   // token pulse
   output uez_rx_t    rx,    // data bytes
   output logic       ack,   // host accepts data
   output uez_reply_t last   // last answer seen
);
   initial
   begin
      tok = '0;
      rx = '0;
      ack = 1'b0;
      last = '0;
   end
   always @(posedge clk)
   begin
      if (reply.valid)
         last <= reply;
   end
   // token, n bytes, then end of packet unless an in token
   task automatic send(input uez_pid_t p, input logic [63:0] b, input int n, input logic ok);
      @(posedge clk);
      tok <= '{1'b1, p, 4'h0};
      last <= '0;
      @(posedge clk);
      tok.valid <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         rx <= '{1'b1, b[8*i +: 8], 1'b0, 1'b0};
         @(posedge clk);
      end
      // released data is inverted so a stale byte never passes for a fresh one
      rx <= '{1'b0, ~rx.data, p != PID_IN, ok};
      @(posedge clk);
      rx.eop <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic hack();
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
   endtask
endmodule

/* src/uez_ctrl.sv */
// Overview of operation
// R1: endpoint zero valid bits always read one
// R2: no pairing bit for endpoints zero/one
// R3: separate 64-byte in and out buffers
// R4: eight-byte setup area for setup stage
// R5: data stage acked only after count loaded
// R6: status nak while hold set, ack after
// R7: status opposite data, else in packet
// R8: stall needs stall plus hold; never setup (code stalls on the stall bit alone)
// R9: next setup token clears stall bit
// R10: setup token sets token request bit
// R11: data request after eight good bytes
// R12: bad setup retried silently, no request
// R13: request bits write-one-clear, always pollable
// R14: setup always accepted, area overwritten
// R15: firmware arms data stage only if length
// R16: two enables gate token/data requests
// R17: set address handled internally, updates address
// R18: interrupt while request and enable set
`timescale 1ns/1ps
module uez_ctrl
   import uez_pkg::*;
(
   input  wire logic        clk,            // core clock, 25 MHz
   input  wire logic        nrst,           // sync reset / usb bus reset, low
   input  wire logic [7:0]  avs_address,    // word address
   input  wire logic        avs_read,       // read request
   input  wire logic        avs_write,      // write request
   input  wire logic [31:0] avs_writedata,  // write data
   output logic      [31:0] avs_readdata,   // read data
   output logic             avs_waitrequest,// stall the master
   output logic             irq,            // processor interrupt
   input  uez_tok_t         tok,            // token from the link
   input  uez_rx_t          rx,             // received data bytes
   input  wire logic        host_ack,       // host acked our data packet
   input  wire logic [5:0]  sie_rd_addr,    // in buffer byte to fetch
   output logic      [7:0]  sie_rd_data,    // fetched byte, one cycle later
   output uez_reply_t       reply,          // handshake or data answer
   output logic      [6:0]  dev_addr        // function address
);
   typedef struct packed
   {
      uez_bph_t   ph;
      logic       wait_r;
      logic [31:0] rdata;
      logic       req_tok;
      logic       req_dat;
      logic       en_tok;
      logic       en_dat;
      logic       stall;
      logic       hold;
      logic       enum_flag;
      logic       in_armed;
      logic       out_armed;
      logic [6:0] in_bc;
      logic [6:0] out_bc;
      logic [7:1] in_val;
      logic [7:1] out_val;
      logic [2:0] pair;
      logic [6:0] fn_addr;
      logic [6:0] pend_addr;
      logic       pend_set;
      uez_stage_t stage;
      uez_pid_t   kind;
      logic       kind_ep0;
      logic [6:0] rx_cnt;
      logic [7:0] bm_type;
      logic [7:0] b_req;
      logic [7:0] w_val_lo;
      logic [15:0] w_len;
      logic       ack_wait;
      logic       ack_status;
      logic       irq;
   } uez_ctrl_st_t;

   uez_ctrl_st_t s;
   uez_ctrl_st_t next_s;
   logic [7:0]   wd;
   logic [7:0]   a_addr;
   logic [7:0]   a_rdata;
   logic [7:0]   b_addr;
   logic         a_we;
   logic         b_we;
   logic         wr_go;
   logic         in_ev;
   logic         setup_ev;
   logic         rx_take;
   logic         rx_end;
   logic         set_addr;

   function automatic logic ram_hit(input logic [7:0] a);
      return a[7:6] == UEZ_WIN_IN[7:6] || a[7:6] == UEZ_WIN_OUT[7:6]
             || a[7:3] == UEZ_WIN_SETUP[7:3];
   endfunction

   function automatic logic [7:0] ram_map(input logic [7:0] a);
      logic [7:0] r;
      r = {UEZ_RAM_SETUP, 3'h0, a[2:0]};
      if (a[7:6] == UEZ_WIN_IN[7:6])
         r = {UEZ_RAM_IN, a[5:0]};
      else if (a[7:6] == UEZ_WIN_OUT[7:6])
         r = {UEZ_RAM_OUT, a[5:0]};
      return r;
   endfunction

   function automatic logic [7:0] reg_read(input uez_ctrl_st_t c, input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         UEZ_REG_IRQ:    r = {6'h00, c.req_dat, c.req_tok}; // R13
         UEZ_REG_IEN:    r = {6'h00, c.en_dat, c.en_tok};
         UEZ_REG_EPCS:   r = {4'h0, c.out_armed, c.in_armed, c.hold, c.stall};
         UEZ_REG_INBC:   r = {1'b0, c.in_bc};
         UEZ_REG_OUTBC:  r = {1'b0, c.out_bc};
         UEZ_REG_INVAL:  r = {c.in_val, 1'b1}; // R1
         UEZ_REG_OUTVAL: r = {c.out_val, 1'b1}; // R1
         UEZ_REG_PAIR:   r = {5'h00, c.pair}; // R2
         UEZ_REG_FUNCTION_ADDRESS_REG: r = {1'b0, c.fn_addr};
         UEZ_REG_ENUM:   r = {7'h00, c.enum_flag};
         default:        r = 8'h00;
      endcase
      return r;
   endfunction

   assign wd       = avs_writedata[7:0];
   assign wr_go    = avs_write && s.ph == BP_DONE;
   assign in_ev    = tok.valid && tok.pid == PID_IN && tok.ep == 4'h0;
   assign setup_ev = tok.valid && tok.pid == PID_SETUP && tok.ep == 4'h0;
   assign rx_take  = rx.valid && s.kind_ep0 && s.kind != PID_IN;
   assign rx_end   = rx.eop && s.kind_ep0 && s.kind != PID_IN;
   assign set_addr = s.enum_flag && s.bm_type == UEZ_STD_DEV_OUT
                     && s.b_req == UEZ_REQ_SET_ADDR;
   assign a_addr   = ram_map(avs_address);
   assign a_we     = wr_go && ram_hit(avs_address);

   // setup bytes land in consecutive slots; out data only while armed
   always_comb
   begin
      b_addr = {UEZ_RAM_IN, sie_rd_addr};
      b_we   = 1'b0;
      if (rx_take && s.kind == PID_SETUP)
      begin
         b_addr = {UEZ_RAM_SETUP, 3'h0, s.rx_cnt[2:0]};
         b_we   = s.rx_cnt < UEZ_SETUP_LEN; // R4 R11 R14
      end
      else if (rx_take)
      begin
         b_addr = {UEZ_RAM_OUT, s.rx_cnt[5:0]};
         b_we   = s.out_armed && s.stage == ST_DOUT && s.rx_cnt < UEZ_MAX_PKT; // R3
      end
   end

   uez_ram
   #(
      .DEPTH (UEZ_RAM_DEPTH),
      .AW    (8),
      .DW    (8)
   )
   u_ram
   (
      .clk     (clk),
      .nrst    (nrst),
      .a_addr  (a_addr),
      .a_we    (a_we),
      .a_wdata (wd),
      .a_rdata (a_rdata),
      .b_addr  (b_addr),
      .b_we    (b_we),
      .b_wdata (rx.data),
      .b_rdata (sie_rd_data)
   );

   uez_resp u_resp
   (
      .clk       (clk),
      .nrst      (nrst),
      .in_ev     (in_ev),
      .rx_end    (rx_end),
      .rx_ok     (rx.ok),
      .kind      (s.kind),
      .rx_cnt    (s.rx_cnt),
      .stage     (s.stage),
      .stall     (s.stall),
      .hold      (s.hold),
      .in_armed  (s.in_armed),
      .out_armed (s.out_armed),
      .in_bc     (s.in_bc),
      .reply     (reply)
   );

   always_comb
   begin
      next_s = s;
      // every access takes three cycles so ram data can be registered before the mux
      case (s.ph)
         BP_IDLE:
         begin
            if (avs_read || avs_write)
               next_s.ph = BP_LOOK;
         end
         BP_LOOK:
         begin
            next_s.ph     = BP_DONE;
            next_s.wait_r = 1'b0;
            next_s.rdata  = {24'h000000,
                             ram_hit(avs_address) ? a_rdata : reg_read(s, avs_address)};
         end
         default:
         begin
            next_s.ph     = BP_IDLE;
            next_s.wait_r = 1'b1;
         end
      endcase

      if (wr_go)
      begin
         case (avs_address)
            UEZ_REG_IRQ:
            begin
               next_s.req_tok = s.req_tok & ~wd[UEZ_B_TOK]; // R13
               next_s.req_dat = s.req_dat & ~wd[UEZ_B_DAT]; // R13
            end
            UEZ_REG_IEN:
            begin
               next_s.en_tok = wd[UEZ_B_TOK]; // R16
               next_s.en_dat = wd[UEZ_B_DAT]; // R16
            end
            UEZ_REG_EPCS:
            begin
               next_s.stall = wd[UEZ_B_STALL]; // R8
               next_s.hold  = s.hold & ~wd[UEZ_B_HOLD]; // R6
            end
            UEZ_REG_INBC:
            begin
               next_s.in_bc    = (wd[6:0] > UEZ_MAX_PKT) ? UEZ_MAX_PKT : wd[6:0];
               next_s.in_armed = 1'b1; // R5
            end
            UEZ_REG_OUTBC:  next_s.out_armed = 1'b1; // R5
            UEZ_REG_INVAL:  next_s.in_val    = wd[7:1]; // R1
            UEZ_REG_OUTVAL: next_s.out_val   = wd[7:1]; // R1
            UEZ_REG_PAIR:   next_s.pair      = wd[2:0]; // R2
            UEZ_REG_ENUM:   next_s.enum_flag = wd[0];
            default:        next_s.pair      = next_s.pair;
         endcase
      end

      // link events come after firmware writes so a request bit set beats a same-cycle clear
      if (tok.valid)
      begin
         next_s.kind     = tok.pid;
         next_s.kind_ep0 = tok.ep == 4'h0;
         next_s.rx_cnt   = 7'h00;
         next_s.ack_wait = 1'b0;
      end
      if (setup_ev)
      begin
         next_s.req_tok   = 1'b1; // R10
         next_s.stall     = 1'b0; // R9
         next_s.hold      = 1'b1;
         // a new transfer aborts the old one; firmware sees it via the token request
         next_s.in_armed  = 1'b0; // R14
         next_s.out_armed = 1'b0;
         next_s.stage     = ST_IDLE;
         next_s.pend_set  = 1'b0;
      end

      if (rx_take)
      begin
         if (s.rx_cnt != UEZ_CNT_MAX)
            next_s.rx_cnt = s.rx_cnt + 7'h01;
         if (s.kind == PID_SETUP)
         begin
            case (s.rx_cnt)
               {4'h0, UEZ_SB_TYPE}:   next_s.bm_type      = rx.data;
               {4'h0, UEZ_SB_REQ}:    next_s.b_req        = rx.data;
               {4'h0, UEZ_SB_VAL}:    next_s.w_val_lo     = rx.data;
               {4'h0, UEZ_SB_LEN_LO}: next_s.w_len[7:0]   = rx.data;
               {4'h0, UEZ_SB_LEN_HI}: next_s.w_len[15:8]  = rx.data;
               default:               next_s.w_len        = next_s.w_len;
            endcase
         end
      end

      if (reply.valid)
      begin
         case (s.kind)
            PID_SETUP:
            begin
               if (reply.code == RC_ACK)
               begin
                  if (s.w_len == 16'h0000)
                     next_s.stage = ST_SIN; // R7
                  else
                     next_s.stage = s.bm_type[UEZ_B_DIR] ? ST_DIN : ST_DOUT;
                  if (set_addr)
                  begin
                     // address moves only after the status stage completes
                     next_s.pend_addr = s.w_val_lo[6:0]; // R17
                     next_s.pend_set  = 1'b1;
                     next_s.hold      = 1'b0;
                  end
                  else
                     next_s.req_dat = 1'b1; // R11
               end
            end
            PID_IN:
            begin
               if (s.stage == ST_DOUT)
                  next_s.stage = ST_SIN; // R7
               if (reply.code == RC_DATA)
               begin
                  next_s.ack_wait   = 1'b1;
                  next_s.ack_status = s.stage != ST_DIN;
               end
            end
            default:
            begin
               if (s.stage == ST_DIN)
                  next_s.stage = ST_SOUT; // R7
               if (reply.code == RC_ACK && s.stage == ST_DOUT)
               begin
                  next_s.out_armed = next_s.out_armed && wr_go && avs_address == UEZ_REG_OUTBC;
                  next_s.out_bc    = s.rx_cnt;
               end
               else if (reply.code == RC_ACK)
                  next_s.stage = ST_IDLE;
            end
         endcase
      end

      if (host_ack && s.ack_wait)
      begin
         next_s.ack_wait = 1'b0;
         if (s.ack_status)
         begin
            next_s.stage    = ST_IDLE;
            next_s.pend_set = 1'b0;
            if (s.pend_set)
               next_s.fn_addr = s.pend_addr; // R17
         end
         else
            next_s.in_armed = next_s.in_armed && wr_go && avs_address == UEZ_REG_INBC;
      end

      next_s.irq = (next_s.req_tok && next_s.en_tok) || (next_s.req_dat && next_s.en_dat); // R18
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         s           <= '0;
         s.wait_r    <= 1'b1;
         s.enum_flag <= UEZ_RST_ENUM;
         s.fn_addr   <= UEZ_RST_ADDR;
      end
      else
         s <= next_s;
   end

   assign avs_readdata    = s.rdata;
   assign avs_waitrequest = s.wait_r;
   assign irq             = s.irq;
   assign dev_addr        = s.fn_addr;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence setup_good_s;
      rx_end && s.kind == PID_SETUP && rx.ok && s.rx_cnt == UEZ_SETUP_LEN;
   endsequence
   sequence acked_s;
      reply.valid && reply.code == RC_ACK;
   endsequence

   valid_read_a: assert property ((avs_read && !avs_waitrequest // R1
      && (avs_address == UEZ_REG_INVAL || avs_address == UEZ_REG_OUTVAL)) |-> avs_readdata[0])
      else $error("endpoint zero valid bit read as zero");
   pair_read_a: assert property ((avs_read && !avs_waitrequest // R2
      && avs_address == UEZ_REG_PAIR) |-> avs_readdata[31:3] == 29'h0)
      else $error("pairing register shows an endpoint zero bit");
   setup_ack_a: assert property (setup_good_s |=> acked_s) // R8 R14
      else $error("good setup packet not acked");
   stall_clear_a: assert property (setup_ev |=> !s.stall && s.hold && s.req_tok) // R9 R10
      else $error("setup token did not clear stall or raise request");
   data_req_a: assert property ((setup_good_s and !set_addr) |=> acked_s ##1 s.req_dat) // R11
      else $error("setup data request missing after good packet");
   err_quiet_a: assert property ((rx_end && s.kind == PID_SETUP && !rx.ok) // R12
      |=> !reply.valid ##1 !$rose(s.req_dat))
      else $error("bad setup packet was answered");
   hold_nak_a: assert property ((in_ev && s.hold && !s.stall && s.stage == ST_SIN) // R6
      |=> reply.valid && reply.code == RC_NAK)
      else $error("status stage not held off");
   arm_nak_a: assert property ((in_ev && s.stage == ST_DIN && !s.in_armed && !s.stall) // R5
      |=> reply.valid && reply.code == RC_NAK)
      else $error("data stage answered before count loaded");
   zl_status_a: assert property ((in_ev && s.stage == ST_SIN && !s.hold && !s.stall) // R7
      |=> reply.code == RC_DATA && reply.len == 7'h00)
      else $error("status in not a zero length packet");
   tok_clear_a: assert property ((wr_go && avs_address == UEZ_REG_IRQ // R13
      && wd[UEZ_B_TOK] && !setup_ev) |=> !s.req_tok)
      else $error("token request not cleared by write of one");
   irq_gate_a: assert property (irq == ((s.req_tok && s.en_tok) || (s.req_dat && s.en_dat))) // R18
      else $error("interrupt does not follow requests and enables");
   addr_move_a: assert property ((host_ack && s.ack_wait && s.ack_status && s.pend_set) // R17
      |=> dev_addr == $past(s.pend_addr))
      else $error("function address not updated after status");
endmodule

/* src/uez_pkg.sv */
package uez_pkg;
   // word offsets on the register bus
   localparam logic [7:0] UEZ_REG_IRQ    = 8'h00;
   localparam logic [7:0] UEZ_REG_IEN    = 8'h01;
   localparam logic [7:0] UEZ_REG_EPCS   = 8'h02;
   localparam logic [7:0] UEZ_REG_INBC   = 8'h03;
   localparam logic [7:0] UEZ_REG_OUTBC  = 8'h04;
   localparam logic [7:0] UEZ_REG_INVAL  = 8'h05;
   localparam logic [7:0] UEZ_REG_OUTVAL = 8'h06;
   localparam logic [7:0] UEZ_REG_PAIR   = 8'h07;
   localparam logic [7:0] UEZ_REG_FUNCTION_ADDRESS_REG = 8'h08;
   localparam logic [7:0] UEZ_REG_ENUM   = 8'h09;
   localparam logic [7:0] UEZ_WIN_SETUP  = 8'h10;
   localparam logic [7:0] UEZ_WIN_IN     = 8'h40;
   localparam logic [7:0] UEZ_WIN_OUT    = 8'h80;
   // buffer ram layout, upper two address bits
   localparam int         UEZ_RAM_DEPTH  = 136;
   localparam logic [1:0] UEZ_RAM_IN     = 2'h0;
   localparam logic [1:0] UEZ_RAM_OUT    = 2'h1;
   localparam logic [1:0] UEZ_RAM_SETUP  = 2'h2;
   localparam logic [6:0] UEZ_SETUP_LEN  = 7'h08;
   localparam logic [6:0] UEZ_MAX_PKT    = 7'h40;
   localparam logic [6:0] UEZ_CNT_MAX    = 7'h7f;
   // setup byte positions
   localparam logic [2:0] UEZ_SB_TYPE    = 3'h0;
   localparam logic [2:0] UEZ_SB_REQ     = 3'h1;
   localparam logic [2:0] UEZ_SB_VAL     = 3'h2;
   localparam logic [2:0] UEZ_SB_LEN_LO  = 3'h6;
   localparam logic [2:0] UEZ_SB_LEN_HI  = 3'h7;
   localparam logic [7:0] UEZ_STD_DEV_OUT  = 8'h00;
   localparam logic [7:0] UEZ_REQ_SET_ADDR = 8'h05;
   // bit positions
   localparam int         UEZ_B_TOK      = 0;
   localparam int         UEZ_B_DAT      = 1;
   localparam int         UEZ_B_STALL    = 0;
   localparam int         UEZ_B_HOLD     = 1;
   localparam int         UEZ_B_INBSY    = 2;
   localparam int         UEZ_B_OUTBSY   = 3;
   localparam int         UEZ_B_DIR      = 7;
   // values after reset
   localparam logic       UEZ_RST_ENUM   = 1'h1;
   localparam logic [6:0] UEZ_RST_ADDR   = 7'h00;

   typedef enum logic [1:0] {PID_OUT = 2'b00, PID_IN = 2'b01, PID_SETUP = 2'b10} uez_pid_t;
   typedef enum logic [2:0]
   {
      RC_NONE = 3'b000, RC_ACK = 3'b001, RC_NAK = 3'b010, RC_STALL = 3'b011, RC_DATA = 3'b100
   } uez_code_t;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000, ST_DIN = 3'b001, ST_DOUT = 3'b010, ST_SIN = 3'b011, ST_SOUT = 3'b100
   } uez_stage_t;
   typedef enum logic [1:0] {BP_IDLE = 2'b00, BP_LOOK = 2'b01, BP_DONE = 2'b10} uez_bph_t;

   typedef struct packed
   {
      logic       valid;
      uez_pid_t   pid;
      logic [3:0] ep;
   } uez_tok_t;
   typedef struct packed
   {
      logic       valid;
      logic [7:0] data;
      logic       eop;
      logic       ok;
   } uez_rx_t;
   typedef struct packed
   {
      logic       valid;
      uez_code_t  code;
      logic [6:0] len;
   } uez_reply_t;
endpackage

/* src/uez_ram.sv */
`timescale 1ns/1ps
module uez_ram
#(
   parameter int DEPTH = 136,
   parameter int AW    = 8,
   parameter int DW    = 8
)
(
   input  wire logic          clk,     // core clock
   input  wire logic          nrst,    // sync reset, low
   input  wire logic [AW-1:0] a_addr,  // bus port address
   input  wire logic          a_we,    // bus port write
   input  wire logic [DW-1:0] a_wdata, // bus port data in
   output logic      [DW-1:0] a_rdata, // bus port data out
   input  wire logic [AW-1:0] b_addr,  // link port address
   input  wire logic          b_we,    // link port write
   input  wire logic [DW-1:0] b_wdata, // link port data in
   output logic      [DW-1:0] b_rdata  // link port data out
);
   logic [DW-1:0] mem [DEPTH];

   // link port wins a same-address collision; the map keeps this out of normal use
   always_ff @(posedge clk)
   begin
      if (a_we)
         mem[a_addr] <= a_wdata;
      if (b_we)
         mem[b_addr] <= b_wdata;
      if (!nrst)
      begin
         a_rdata <= '0;
         b_rdata <= '0;
      end
      else
      begin
         a_rdata <= mem[a_addr];
         b_rdata <= mem[b_addr];
      end
   end
endmodule

/* src/uez_resp.sv */
`timescale 1ns/1ps
module uez_resp
   import uez_pkg::*;
(
   input  wire logic        clk,      // core clock
   input  wire logic        nrst,     // sync reset, low
   input  wire logic        in_ev,    // in token for endpoint zero
   input  wire logic        rx_end,   // end of setup or out data packet
   input  wire logic        rx_ok,    // packet crc good
   input  uez_pid_t         kind,     // token kind of current packet
   input  wire logic [6:0]  rx_cnt,   // bytes received
   input  uez_stage_t       stage,    // control transfer stage
   input  wire logic        stall,    // endpoint zero stall
   input  wire logic        hold,     // handshake hold
   input  wire logic        in_armed, // in byte count loaded
   input  wire logic        out_armed,// out byte count loaded
   input  wire logic [6:0]  in_bc,    // in byte count
   output uez_reply_t       reply     // answer to the link
);
   uez_reply_t next_reply;
   logic       st_in;
   logic       st_out;

   assign st_in  = (stage == ST_SIN) || (stage == ST_DOUT);
   assign st_out = (stage == ST_SOUT) || (stage == ST_DIN);

   always_comb
   begin
      next_reply = '0;
      if (in_ev)
      begin
         next_reply.valid = 1'b1;
         if (stall)
            next_reply.code = RC_STALL; // R8
         else if (stage == ST_DIN)
         begin
            next_reply.code = in_armed ? RC_DATA : RC_NAK; // R5
            next_reply.len  = in_bc;
         end
         else if (st_in)
            next_reply.code = hold ? RC_NAK : RC_DATA; // R6 R7
         else
            next_reply.code = RC_NAK;
      end
      else if (rx_end && rx_ok)
      begin
         // a bad packet gets no answer at all, so the host retries on its own
         next_reply.valid = 1'b1; // R12
         if (kind == PID_SETUP)
            next_reply.code = (rx_cnt == UEZ_SETUP_LEN) ? RC_ACK : RC_NONE; // R8 R14
         else if (stall)
            next_reply.code = RC_STALL; // R8
         else if (stage == ST_DOUT)
            next_reply.code = (out_armed && rx_cnt <= UEZ_MAX_PKT) ? RC_ACK : RC_NAK; // R5
         else if (st_out)
            next_reply.code = hold ? RC_NAK : RC_ACK; // R6 R7
         else
            next_reply.code = RC_NAK;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         reply <= '0;
      else
         reply <= next_reply;
   end
endmodule
